// ---- rtl/alarm_report_pkg.sv ----
package alarm_report_pkg;
    localparam int NCH = 8;
    localparam int NALM = 6;
    localparam int NALL = NCH * NALM;
    localparam int NFLT = NALL + 2;
    localparam int CFG_W = 21;
    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_FAULT = 12'h008;
    localparam logic [11:0] OFF_IRQ = 12'h00C;
    localparam logic [11:0] CFG_BASE = 12'h040;
    localparam logic [11:0] VAL_BASE = 12'h080;
    localparam logic [11:0] DIAG_BASE = 12'h0C0;
    // Control register bits; store and scan are write-one pulses.
    localparam int CTRL_STORE_BIT = 0;
    localparam int CTRL_SCAN_BIT = 1;
    localparam int CTRL_IOEN_BIT = 2;
    localparam int CTRL_STATEN_BIT = 3;
    // Channel configuration fields.
    localparam int DIAG_EN_LSB = 0;
    localparam int FAULT_EN_LSB = 6;
    localparam int IRQ_EN_LSB = 12;
    localparam int FMT_FLOAT_BIT = 18;
    localparam int CURR_BIT = 19;
    localparam int CHEN_BIT = 20;
    localparam logic [CFG_W-1:0] CFG_RST = 21'h00_0000;
    // Module status bits.
    localparam int STAT_CFG_BIT = 0;
    localparam int STAT_ALM_BIT = 1;
    localparam int STAT_TB_BIT = 2;
    localparam int STAT_FLT_BIT = 3;
    localparam logic [3:0] STAT_RST = 4'h0;
    // Fault entry layout.
    localparam int ENT_VALID_BIT = 31;
    localparam logic [1:0] KIND_ALARM = 2'h0;
    localparam logic [1:0] KIND_TB_LOSS = 2'h1;
    localparam logic [1:0] KIND_TB_ADD = 2'h2;
    localparam int IDX_TB_LOSS = NALL;
    localparam int IDX_TB_ADD = NALL + 1;
endpackage

// ---- rtl/alarm_report.sv ----
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
// Functional notes
// [R01] After reset every diagnostic, fault and interrupt response is disabled.
// [R02] Each alarm type per channel has independent diag/fault/irq enables.
// [R03] Enabled diagnostic alarms appear in that channel's diagnostic words.
// [R04] Every enabled alarm occurrence queues exactly one fault entry; the logic queues none for a repeat while that alarm's entry is still pending.
// [R05] Enabled alarm occurrence raises an interrupt request to the controller.
// [R06] Controller sets interrupt enables and binds handler to channel address.
// [R07] Interrupting condition shows its diagnostic bit even with diagnostics off.
// [R08] Next input scan returns such a diagnostic bit to zero.
// [R09] Channel values use two words per channel, channel n at 2(n-1).
// [R10] Value format per channel is 32-bit float or 16-bit integer.
// [R11] Integer format uses signed low word and ignores the high word.
// [R12] Controller keeps integer values within the signed 16-bit range.
// [R13] Diagnostic data uses two words per channel at word 2(n-1).
// [R14] Diagnostic bit is one only while alarm present and detection enabled.
// [R15] Four module status bits are reported in a 32-bit status area.
// [R16] Terminal block indicator is green when present, red when absent.
// [R17] Each terminal block insertion or removal logs an add or loss entry; the logic logs them only once a configuration has been stored.
// [R18] Storing a configuration without terminal block logs a loss entry.
// [R19] Module status bit two reflects terminal block presence.
// [R20] Module status refreshes only while input/output scanning is enabled.
// [R21] Each channel drives voltage or current output, never both.
module alarm_report
    import alarm_report_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NALL-1:0] alarm_i,
    input wire logic tb_present_i,
    output logic irq_req_o,
    output logic terminal_block_indicator_green_o,
    output logic terminal_block_indicator_red_o,
    output logic [NCH*32-1:0] chan_value_o,
    output logic [NCH-1:0] chan_float_o,
    output logic [NCH-1:0] volt_drive_o,
    output logic [NCH-1:0] curr_drive_o
);

    function automatic logic [5:0] first_set(input logic [NFLT-1:0] v);
        logic [5:0] idx;
        idx = 6'h00;
        for (int i = NFLT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    logic tb_s1_r;
    logic tb_s2_r;
    logic tb_d_r;
    logic ack_r;
    logic ioen_r;
    logic staten_r;
    logic cfg_done_r;
    logic [CFG_W-1:0] cfg_r [NCH];
    logic [15:0] value_r [2*NCH];
    logic [NALL-1:0] alarm_d_r;
    logic [NALL-1:0] diag_r;
    logic [NFLT-1:0] fault_pend_r;
    logic [NCH-1:0] irq_pend_r;
    logic [3:0] stat_r;
    logic [31:0] rdata_r;
    logic [5:0] fpop_idx_r;
    logic fpop_v_r;
    logic [2:0] ipop_idx_r;
    logic ipop_v_r;
    logic [NCH*32-1:0] chan_value_r;
    logic [NCH-1:0] chan_float_r;
    logic [NCH-1:0] volt_r;
    logic [NCH-1:0] curr_r;
    logic led_green_r;

    // Bus handshake: one wait cycle, answer on the second edge.
    wire req = avs_read_i | avs_write_i;
    wire first = req & ~ack_r;
    wire acc = req & ack_r;
    assign avs_waitrequest_o = first;
    assign avs_readdata_o = rdata_r;

    wire [11:0] a = avs_address_i;
    wire sel_ctrl = a == OFF_CTRL;
    wire sel_stat = a == OFF_STATUS;
    wire sel_flt = a == OFF_FAULT;
    wire sel_irq = a == OFF_IRQ;
    wire sel_cfg = a[11:5] == CFG_BASE[11:5];
    wire sel_val = a[11:6] == VAL_BASE[11:6];
    wire sel_diag = a[11:6] == DIAG_BASE[11:6];
    wire [2:0] cfg_idx = a[4:2];
    wire [3:0] word_idx = a[5:2];
    wire [2:0] word_ch = a[5:3];

    // Per-bit enables gathered from the channel configuration.
    logic [NALL-1:0] diag_en_v;
    logic [NALL-1:0] fault_en_v;
    logic [NALL-1:0] irq_en_v;
    logic [NALL-1:0] alm_ch_en_v;
    logic [NCH-1:0] chen_v;
    logic [NCH-1:0] float_v;
    logic [NCH-1:0] curr_v;
    logic [NCH-1:0] irq_ch_set;
    logic [NALL-1:0] rise;
    logic [NALL-1:0] fault_set;
    logic [NALL-1:0] irq_set;

    assign rise = alarm_i & ~alarm_d_r & alm_ch_en_v;
    // [R02] Independent enable mix.
    assign fault_set = rise & fault_en_v;
    assign irq_set = rise & irq_en_v;

    genvar g;

    // Fault entry and interrupt source selection for the pop registers.
    wire [5:0] fsel = first_set(fault_pend_r);
    wire fany = |fault_pend_r;
    wire [5:0] isel6 = first_set({{(NFLT-NCH){1'b0}}, irq_pend_r});
    wire [2:0] isel = isel6[2:0];
    wire iany = |irq_pend_r;
    wire [1:0] fkind = (fsel == 6'(IDX_TB_LOSS)) ? KIND_TB_LOSS :
                       (fsel == 6'(IDX_TB_ADD)) ? KIND_TB_ADD : KIND_ALARM;
    wire [2:0] fch = (fkind == KIND_ALARM) ? 3'(fsel / 6'(NALM)) : 3'h0;
    wire [2:0] falm = (fkind == KIND_ALARM) ? 3'(fsel % 6'(NALM)) : 3'h0;
    wire [31:0] fent = {fany, 21'h00_0000, fkind, 1'b0, fch, 1'b0, falm};
    // [R09] Interrupt source as the channel's value word offset.
    wire [31:0] ient = {iany, 27'h000_0000, isel, 1'b0};

    // [R13] Diagnostic word pairs; the upper word of a pair reads zero.
    wire [15:0] diag_word = word_idx[0] ? 16'h0000 :
                            16'(diag_r[word_ch*NALM +: NALM]);
    wire [31:0] ctrl_rd = 32'({staten_r, ioen_r, 2'b00});
    wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                         sel_stat ? 32'(stat_r) :
                         sel_flt ? fent :
                         sel_irq ? ient :
                         sel_cfg ? 32'(cfg_r[cfg_idx]) :
                         sel_val ? 32'(value_r[word_idx]) :
                         sel_diag ? 32'(diag_word) : 32'h0000_0000;
    wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire [31:0] wmerge = (avs_writedata_i & be_mask) | (rd_mux & ~be_mask);

    wire wr_acc = acc & avs_write_i;
    wire wr_ctrl = wr_acc & sel_ctrl;
    wire store_pulse = wr_ctrl & wmerge[CTRL_STORE_BIT];
    wire scan_pulse = wr_ctrl & wmerge[CTRL_SCAN_BIT];
    wire fpop = acc & avs_read_i & sel_flt & fpop_v_r;
    wire ipop = acc & avs_read_i & sel_irq & ipop_v_r;
    // The scan is gated by the mode held before this write, so a write that
    // clears the mode together with a scan still refreshes the status once.
    wire stat_upd = scan_pulse & ioen_r & staten_r;

    // [R17] Terminal block edges after configuration.
    wire tb_loss = cfg_done_r & tb_d_r & ~tb_s2_r;
    wire tb_add = cfg_done_r & ~tb_d_r & tb_s2_r;
    // [R18] Loss logged on store without block.
    wire tb_store_loss = store_pulse & ~tb_s2_r;
    wire [NFLT-1:0] flt_set_all = {tb_add, tb_loss | tb_store_loss, fault_set};
    wire [NFLT-1:0] fpop_mask = fpop ? (NFLT'(1) << fpop_idx_r) : '0;
    wire [NCH-1:0] ipop_mask = ipop ? (NCH'(1) << ipop_idx_r) : '0;

    // [R03] Diagnostic refresh at input scan.
    // [R14] Only present and enabled alarms read one.
    // [R07] Interrupting condition forces its bit.
    // [R08] The scan clears bits whose diagnostics are off.
    wire [NALL-1:0] diag_nxt = scan_pulse ?
        ((alarm_i & diag_en_v & alm_ch_en_v) | irq_set) : (diag_r | irq_set);

    // [R04] Set wins over the pop of the same entry.
    wire [NFLT-1:0] fault_nxt = flt_set_all | (fault_pend_r & ~fpop_mask);
    // [R05] Interrupt request per channel.
    wire [NCH-1:0] irq_nxt = irq_ch_set | (irq_pend_r & ~ipop_mask);
    // The request is a level that stays up until every pending channel has
    // been read out, so no occurrence is lost between handler runs.
    assign irq_req_o = |irq_pend_r;

    // [R15] Four status bits.
    // [R19] Terminal block on bit two.
    wire [3:0] stat_nxt = {fany, tb_s2_r, |(diag_r | alarm_i & alm_ch_en_v),
                           cfg_done_r};

    // The first synchroniser stage feeds only the second.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tb_s1_r <= 1'b0;
            tb_s2_r <= 1'b0;
            tb_d_r <= 1'b0;
        end else begin
            tb_s1_r <= tb_present_i;
            tb_s2_r <= tb_s1_r;
            tb_d_r <= tb_s2_r;
        end
    end

    // Pop targets are latched on the first edge so the entry read is the
    // entry removed, even if a higher-priority event arrives meanwhile.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            fpop_idx_r <= 6'h00;
            fpop_v_r <= 1'b0;
            ipop_idx_r <= 3'h0;
            ipop_v_r <= 1'b0;
        end else begin
            ack_r <= first;
            if (first) begin
                rdata_r <= avs_read_i ? rd_mux : 32'h0000_0000;
                fpop_idx_r <= fsel;
                fpop_v_r <= fany;
                ipop_idx_r <= isel;
                ipop_v_r <= iany;
            end
        end
    end

    // [R01] Responses disabled at reset.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_r[i] <= CFG_RST;
            end
            ioen_r <= 1'b0;
            staten_r <= 1'b0;
            cfg_done_r <= 1'b0;
        end else begin
            if (wr_acc & sel_cfg) begin
                cfg_r[cfg_idx] <= wmerge[CFG_W-1:0];
            end
            if (wr_ctrl) begin
                ioen_r <= wmerge[CTRL_IOEN_BIT];
                staten_r <= wmerge[CTRL_STATEN_BIT];
            end
            if (store_pulse) begin
                cfg_done_r <= 1'b1;
            end
        end
    end

    // [R09] Two value words per channel.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 2 * NCH; i++) begin
                value_r[i] <= 16'h0000;
            end
        end else if (wr_acc & sel_val) begin
            value_r[word_idx] <= wmerge[15:0];
        end
    end

    // [R20] Status refresh only with scanning enabled.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_d_r <= '0;
            diag_r <= '0;
            fault_pend_r <= '0;
            irq_pend_r <= '0;
            stat_r <= STAT_RST;
        end else begin
            alarm_d_r <= alarm_i;
            diag_r <= diag_nxt;
            fault_pend_r <= fault_nxt;
            irq_pend_r <= irq_nxt;
            if (stat_upd) begin
                stat_r <= stat_nxt;
            end
        end
    end

    // [R10] Float or integer per channel.
    // [R11] Integer takes the signed low word.
    // [R21] Voltage and current drive are exclusive.
    // One loop holds every per-channel slice, configuration decode included.
    generate
        for (g = 0; g < NCH; g++) begin : g_out
            assign chen_v[g] = cfg_r[g][CHEN_BIT];
            assign float_v[g] = cfg_r[g][FMT_FLOAT_BIT];
            assign curr_v[g] = cfg_r[g][CURR_BIT];
            assign diag_en_v[g*NALM +: NALM] = cfg_r[g][DIAG_EN_LSB +: NALM];
            assign fault_en_v[g*NALM +: NALM] = cfg_r[g][FAULT_EN_LSB +: NALM];
            assign irq_en_v[g*NALM +: NALM] = cfg_r[g][IRQ_EN_LSB +: NALM];
            assign alm_ch_en_v[g*NALM +: NALM] = {NALM{cfg_r[g][CHEN_BIT]}};
            assign irq_ch_set[g] = |irq_set[g*NALM +: NALM];
            wire [15:0] lo = value_r[2*g];
            wire [15:0] hi = value_r[2*g+1];
            wire [31:0] v = float_v[g] ? {hi, lo} : {{16{lo[15]}}, lo};
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    chan_value_r[g*32 +: 32] <= 32'h0000_0000;
                    chan_float_r[g] <= 1'b0;
                    volt_r[g] <= 1'b0;
                    curr_r[g] <= 1'b0;
                end else begin
                    chan_value_r[g*32 +: 32] <= chen_v[g] ? v : 32'h0000_0000;
                    chan_float_r[g] <= chen_v[g] & float_v[g];
                    volt_r[g] <= chen_v[g] & ~curr_v[g];
                    curr_r[g] <= chen_v[g] & curr_v[g];
                end
            end
        end
    endgenerate

    // [R16] Indicator follows presence.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            led_green_r <= 1'b0;
        end else begin
            led_green_r <= tb_s2_r;
        end
    end

    assign chan_value_o = chan_value_r;
    assign chan_float_o = chan_float_r;
    assign volt_drive_o = volt_r;
    assign curr_drive_o = curr_r;
    assign terminal_block_indicator_green_o = led_green_r;
    assign terminal_block_indicator_red_o = ~led_green_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    bus_answer_a: assert property (first |=> !avs_waitrequest_o)
        else $error("Bus answer did not follow the wait cycle.");
    fault_log_a: assert property ( // [R04]
        |fault_set |=> ((fault_pend_r & $past(fault_set)) == $past(fault_set)))
        else $error("Alarm occurrence left no fault entry.");
    irq_raise_a: assert property (|irq_set |=> irq_req_o) // [R05]
        else $error("Enabled alarm raised no interrupt request.");
    irq_drop_a: assert property (ipop && !(|irq_ch_set) && // [R05]
        irq_pend_r == (NCH'(1) << ipop_idx_r) |=> !irq_req_o)
        else $error("Interrupt request stayed up after the last pop.");
    diag_irq_a: assert property ( // [R07]
        |irq_set |=> ((diag_r & $past(irq_set)) == $past(irq_set)))
        else $error("Interrupting condition left its diagnostic bit clear.");
    diag_scan_a: assert property ( // [R08]
        scan_pulse && !(|irq_set) |=>
        diag_r == $past(alarm_i & diag_en_v & alm_ch_en_v))
        else $error("Scan left a disabled diagnostic bit set.");
    int_format_a: assert property ( // [R11]
        !chan_float_o[2] |-> chan_value_o[95:80] == {16{chan_value_o[79]}})
        else $error("Integer channel value not sign extended.");
    drive_excl_a: assert property (!(|(volt_drive_o & curr_drive_o))) // [R21]
        else $error("Channel drives voltage and current together.");
    tb_led_a: assert property ( // [R16]
        terminal_block_indicator_green_o == $past(tb_s2_r) &&
        terminal_block_indicator_green_o != terminal_block_indicator_red_o)
        else $error("Terminal block indicator wrong.");
    tb_store_a: assert property ( // [R18]
        tb_store_loss |=> fault_pend_r[IDX_TB_LOSS])
        else $error("Store without terminal block logged no loss.");
    tb_loss_a: assert property ( // [R17]
        tb_loss |=> fault_pend_r[IDX_TB_LOSS])
        else $error("Terminal block removal logged no loss entry.");
    tb_add_a: assert property ( // [R17]
        tb_add |=> fault_pend_r[IDX_TB_ADD])
        else $error("Terminal block insertion logged no add entry.");
    tb_status_a: assert property (stat_upd |=> // [R19]
        stat_r[STAT_TB_BIT] == $past(tb_s2_r))
        else $error("Status bit two does not show terminal block.");
    stat_hold_a: assert property (!ioen_r |=> $stable(stat_r)) // [R20]
        else $error("Status refreshed while scanning disabled.");

    fault_pop_c: cover property (fpop ##1 fany);
    irq_diag_c: cover property (|irq_set ##[1:20] scan_pulse);
    tb_remove_c: cover property (tb_loss ##[1:50] tb_add);
    float_out_c: cover property (chan_float_o[2] && volt_drive_o[2]);
    stat_refresh_c: cover property (stat_upd ##1 stat_r[STAT_TB_BIT]);

endmodule // alarm_report

// ---- dv/cpu_model.sv ----
`timescale 1ns/10ps
module cpu_model (
    input wire logic clk_i,
    input wire logic avs_waitrequest_i,
    input wire logic [31:0] avs_readdata_i,
    output logic [11:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o
);
    initial begin
        avs_address_o = 12'h000;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0000_0000;
        avs_byteenable_o = 4'hF;
    end

    // Call just after a rising edge. Released address and data lines show the inverse value,
    // so a slave that samples stale data cannot pass by luck.
    task automatic access(input logic wr, input logic [11:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        avs_address_o <= a;
        avs_writedata_o <= d;
        avs_write_o <= wr;
        avs_read_o <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest_i !== 1'b0) begin
            @(posedge clk_i);
        end
        q = avs_readdata_i;
        avs_write_o <= 1'b0;
        avs_read_o <= 1'b0;
        avs_address_o <= ~a;
        avs_writedata_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule // cpu_model

// ---- dv/alarm_report_tb_top.sv ----
`timescale 1ns/10ps
module alarm_report_tb_top;
    import alarm_report_pkg::*;
    typedef struct {
        logic [11:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] e;
    } row_s;
    logic clk_i;
    logic nrst_i;
    logic [11:0] adr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wdat;
    logic [3:0] ben;
    logic [31:0] rdat;
    logic wait_s;
    logic [NALL-1:0] alarm_i;
    logic tb_present_i;
    logic irq_req_o;
    logic green;
    logic red;
    logic [NCH*32-1:0] chan_value_o;
    logic [NCH-1:0] chan_float_o;
    logic [NCH-1:0] volt_drive_o;
    logic [NCH-1:0] curr_drive_o;
    logic [31:0] q;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    row_s rows [7] = '{
        '{CFG_BASE, 1'b0, 32'h0, 32'h0},
        '{CFG_BASE + 12'h01C, 1'b0, 32'h0, 32'h0},
        '{12'h3FC, 1'b1, 32'hFFFF_FFFF, 32'h0},
        '{DIAG_BASE, 1'b0, 32'h0, 32'h0},
        '{OFF_STATUS, 1'b0, 32'h0, 32'h0},
        '{CFG_BASE + 12'h004, 1'b1, 32'h001F_FFFF, 32'h001F_FFFF},
        '{CFG_BASE + 12'h008, 1'b1, 32'h0015_5555, 32'h0015_5555}
    };

    alarm_report alarm_report_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_s), .alarm_i(alarm_i),
        .tb_present_i(tb_present_i), .irq_req_o(irq_req_o),
        .terminal_block_indicator_green_o(green),
        .terminal_block_indicator_red_o(red),
        .chan_value_o(chan_value_o), .chan_float_o(chan_float_o),
        .volt_drive_o(volt_drive_o), .curr_drive_o(curr_drive_o)
    );

    cpu_model cpu_model_inst (
        .clk_i(clk_i), .avs_waitrequest_i(wait_s), .avs_readdata_i(rdat),
        .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s),
        .avs_writedata_o(wdat), .avs_byteenable_o(ben)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        cpu_model_inst.access(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        cpu_model_inst.access(1'b0, a, 32'h0, r);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        nrst_i = 1'b0;
        tb_present_i = 1'b1;
        alarm_i = '0;
        repeat (10) @(posedge clk_i);
        check({30'h0, irq_req_o, red}, 32'h1);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({30'h0, green, red}, 32'h2);
        for (int i = 0; i < 7; i++) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, q);
            check(q, rows[i].e);
        end
        check({26'h0, chan_float_o[2:1], volt_drive_o[2:1],
               curr_drive_o[2:1]}, 32'h0000_0039);
        // Fault and interrupt enables for one alarm type.
        wr(CFG_BASE + 12'h00C, 32'h0010_8200);
        alarm_i[21] <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_req_o}, 32'h1);
        rd(DIAG_BASE + 12'h018, q);
        check(q, 32'h0000_0008);
        rd(OFF_IRQ, q);
        check(q, 32'h8000_0006);
        check({31'h0, irq_req_o}, 32'h0);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0033);
        rd(OFF_FAULT, q);
        check({31'h0, q[31]}, 32'h0);
        wr(OFF_CTRL, 32'h0000_0002);
        rd(DIAG_BASE + 12'h018, q);
        check(q, 32'h0);
        alarm_i[21] <= 1'b0;
        repeat (2) @(posedge clk_i);
        alarm_i[21] <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0033);
        rd(OFF_IRQ, q);
        check(q, 32'h8000_0006);
        wr(CFG_BASE + 12'h008, 32'h0010_0001);
        alarm_i[12] <= 1'b1;
        @(posedge clk_i);
        wr(OFF_CTRL, 32'h0000_0002);
        rd(DIAG_BASE + 12'h010, q);
        check(q, 32'h1);
        rd(DIAG_BASE + 12'h014, q);
        check(q, 32'h0);
        rd(OFF_FAULT, q);
        check({30'h0, irq_req_o, q[31]}, 32'h0);
        // Integer values stay inside the signed 16-bit range.
        wr(VAL_BASE + 12'h010, 32'h0000_8001);
        wr(VAL_BASE + 12'h014, 32'h0000_7FFF);
        @(posedge clk_i);
        check(chan_value_o[64 +: 32], 32'hFFFF_8001);
        check(chan_value_o[96 +: 32], 32'h0000_0000);
        check({30'h0, chan_float_o[2], volt_drive_o[2]}, 32'h1);
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_FAULT, q);
        check({31'h0, q[31]}, 32'h0);
        tb_present_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check({30'h0, green, red}, 32'h1);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0100);
        // The scan is gated by the mode held before the write.
        wr(OFF_CTRL, 32'h0000_000C);
        wr(OFF_CTRL, 32'h0000_000E);
        rd(OFF_STATUS, q);
        check(q, 32'h0000_0003);
        tb_present_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0200);
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0002);
        rd(OFF_STATUS, q);
        check(q & 32'h4, 32'h0);
        wr(OFF_CTRL, 32'h0000_000C);
        wr(OFF_CTRL, 32'h0000_000E);
        rd(OFF_STATUS, q);
        check(q & 32'h4, 32'h4);
        tb_present_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0100);
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_FAULT, q);
        check(q, 32'h8000_0100);
        report_and_stop();
    end
endmodule // alarm_report_tb_top
